// ---- dv/fpa_panel_model.sv ----
// Operator model: four pushbutton pins of the front panel.
// Assumes the panel samples the pins on rising edges of clk.
`timescale 1ns/1ps
module fpa_panel_model
	import fpa_pkg::*;
(
	// Clock
	input wire logic clk,
	// Button pins, active high
	output logic btnMode,
	output logic btnUp,
	output logic btnDown,
	output logic btnSet
);
	// ==========================================
	// Pin levels
	logic [3:0] pins = 4'h0;
	assign btnMode = pins[B_MODE];
	assign btnUp = pins[B_UP];
	assign btnDown = pins[B_DOWN];
	assign btnSet = pins[B_SET];
	// Hold past the two sync flops, then release so the next press is a fresh edge
	task automatic press(input int b);
	begin
		@(posedge clk);
		pins <= 4'h1 << b;
		repeat (4) @(posedge clk);
		pins <= 4'h0;
		repeat (4) @(posedge clk);
	end
	endtask
endmodule // fpa_panel_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the front panel: APB master, alarm source, buttons.
// Assumes the one-wait-state APB slave and short blink divider set below.
`timescale 1ns/1ps
module tb_top;
	import fpa_pkg::*;
	// Short blink half period keeps the run brief
	localparam int HALF = 8;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, alarmNumber, regenOption;
	logic [31:0] pwdata, prdata, rdata;
	logic btnMode, btnUp, btnDown, btnSet, dpThird, alarmActive, contactorEnable;
	logic alarmEvent, alarmCauseGone, alarmClearable, powerCycle;
	logic [6:0] digitSeg2, digitSeg1, digitSeg0;
	logic [15:0] powerFailTime;
	logic segOn, segOff, dp0, dp1;
	logic [15:0] rstVal [8] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0001, 16'h00C8};
	int num_errors = 0;
	int comparisons = 0;
	// ==========================================
	// Design and operator
	fpa_front_panel #(.BLINK_HALF(HALF)) u_fpa_front_panel (.clk(clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .btnMode(btnMode), .btnUp(btnUp), .btnDown(btnDown),
		.btnSet(btnSet), .alarmEvent(alarmEvent), .alarmNumber(alarmNumber),
		.alarmCauseGone(alarmCauseGone), .alarmClearable(alarmClearable), .powerCycle(powerCycle),
		.digitSeg2(digitSeg2), .digitSeg1(digitSeg1), .digitSeg0(digitSeg0), .dpThird(dpThird),
		.alarmActive(alarmActive), .contactorEnable(contactorEnable), .regenOption(regenOption),
		.powerFailTime(powerFailTime));
	fpa_panel_model u_fpa_panel_model (.clk(clk), .btnMode(btnMode), .btnUp(btnUp), .btnDown(btnDown),
		.btnSet(btnSet));
	// ==========================================
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ==========================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		apb(1'b1, a, d);
		repeat (2) @(posedge clk);
	end
	endtask
	task automatic pwr();
	begin
		@(posedge clk);
		powerCycle <= 1'b1;
		@(posedge clk);
		powerCycle <= 1'b0;
		repeat (3) @(posedge clk);
	end
	endtask
	task automatic raise(input logic [7:0] num);
	begin
		@(posedge clk);
		alarmEvent <= 1'b1;
		alarmNumber <= num;
		@(posedge clk);
		alarmEvent <= 1'b0;
	end
	endtask
	// Watch two blink periods, sampling where outputs are settled
	task automatic scan(input logic [6:0] seg);
	begin
		{segOn, segOff, dp0, dp1} = 4'h0;
		repeat (4 * HALF + 4)
		begin
			@(negedge clk);
			segOn |= (digitSeg0 === seg);
			segOff |= (digitSeg0 === 7'h00);
			dp0 |= (dpThird === 1'b0);
			dp1 |= (dpThird === 1'b1);
		end
	end
	endtask
	task automatic report_and_stop();
	begin
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// ==========================================
	// Watchdog: the tests need well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	// ==========================================
	// Tests
	initial
	begin
		{resetn, psel, penable, pwrite, alarmEvent, alarmCauseGone, alarmClearable, powerCycle} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		alarmNumber = 8'h00;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(8'(4 * i), {16'h0000, rstVal[i]});
		check(32'(contactorEnable), 32'h1);
		check(32'(powerFailTime), 32'hC8);
		apb(1'b0, 8'h3C, 32'h0);
		check(32'(err), 32'h1);
		wr(8'h20, 32'hFFFF);
		rd(8'h20, 32'h0);
		$display("test registers done");
		// Starred settings wait for a power-on, plain ones act at once
		wr(8'h04, 32'h0);
		check(32'(contactorEnable), 32'h1);
		pwr();
		check(32'(contactorEnable), 32'h0);
		wr(8'h04, 32'h1);
		pwr();
		check(32'(contactorEnable), 32'h1);
		wr(8'h00, 32'h13);
		check(32'(regenOption), 32'h0);
		pwr();
		check(32'(regenOption), 32'h13);
		wr(8'h1C, 32'h64);
		check(32'(powerFailTime), 32'h64);
		wr(8'h00, 32'h05);
		pwr();
		rd(8'h20, 32'h3703);
		alarmCauseGone <= 1'b1;
		alarmClearable <= 1'b1;
		wr(8'h00, 32'h0);
		pwr();
		check(32'(alarmActive), 32'h0);
		alarmCauseGone <= 1'b0;
		alarmClearable <= 1'b0;
		$display("test parameters done");
		// Alarm display, screen forcing and clearing
		raise(8'h33);
		repeat (2) @(posedge clk);
		check(32'(alarmActive), 32'h1);
		rd(8'h20, 32'h3301);
		rd(8'h24, 32'h133);
		scan(7'h4F);
		check(32'(segOn & segOff), 32'h1);
		u_fpa_panel_model.press(B_UP);
		scan(7'h4F);
		check(32'(dp0 & dp1), 32'h1);
		raise(8'h50);
		scan(7'h3F);
		check(32'(segOn & segOff), 32'h1);
		u_fpa_panel_model.press(B_SET);
		check(32'(alarmActive), 32'h1);
		alarmCauseGone <= 1'b1;
		alarmClearable <= 1'b1;
		u_fpa_panel_model.press(B_SET);
		check(32'(alarmActive), 32'h0);
		rd(8'h24, 32'h150);
		rd(8'h28, 32'h133);
		$display("test alarm done");
		// History depth and erase by the history clear setting
		for (int k = 0; k < 7; k++)
			raise(8'(8'h10 + k));
		for (int k = 0; k < 6; k++)
			rd(8'(8'h24 + 4 * k), 32'(32'h116 - k));
		wr(8'h0C, 32'h1);
		rd(8'h24, 32'h116);
		pwr();
		rd(8'h24, 32'h0);
		rd(8'h0C, 32'h0);
		$display("test history done");
		// Parameter mode: alternation, stepping, fourth digit, commit
		u_fpa_panel_model.press(B_MODE);
		scan(7'h06);
		check(32'(segOn & segOff), 32'h1);
		u_fpa_panel_model.press(B_UP);
		scan(7'h5B);
		check(32'(segOn & segOff), 32'h1);
		u_fpa_panel_model.press(B_SET);
		check(32'(digitSeg0), 32'h06);
		check(32'(digitSeg2), 32'h3F);
		u_fpa_panel_model.press(B_MODE);
		check(32'(digitSeg0), 32'h3F);
		check(32'(digitSeg1), 32'h00);
		u_fpa_panel_model.press(B_MODE);
		u_fpa_panel_model.press(B_UP);
		check(32'(digitSeg0), 32'h5B);
		u_fpa_panel_model.press(B_SET);
		rd(8'h04, 32'h2);
		check(32'(contactorEnable), 32'h1);
		$display("test parameter mode done");
		report_and_stop();
	end
endmodule // tb_top

// ---- logic/fpa_front_panel.sv ----
// Front panel controller: alarm screens, history and parameter editing.
// Assumes APB master on clk, buttons from pins, alarm inputs from clk logic.
`timescale 1ns/1ps
module fpa_front_panel #(
	parameter int BLINK_HALF = fpa_pkg::BLINK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pushbuttons, active high levels from pins
	input wire logic btnMode,
	input wire logic btnUp,
	input wire logic btnDown,
	input wire logic btnSet,
	// Alarm source and power cycle event
	input wire logic alarmEvent,
	input wire logic [7:0] alarmNumber,
	input wire logic alarmCauseGone,
	input wire logic alarmClearable,
	input wire logic powerCycle,
	// Display
	output logic [6:0] digitSeg2,
	output logic [6:0] digitSeg1,
	output logic [6:0] digitSeg0,
	output logic dpThird,
	// Active settings
	output logic alarmActive,
	output logic contactorEnable,
	output logic [7:0] regenOption,
	output logic [15:0] powerFailTime
);
	import fpa_pkg::*;

	localparam int BW = $clog2(BLINK_HALF);
	localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF - 1);

	// Divider needs at least two states to toggle
	if (BLINK_HALF < 2) begin : g_bad_blink
		$error("BLINK_HALF must be at least 2");
	end

	logic [3:0] btnRaw;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] prev_q;
	logic [3:0] press;
	logic [15:0] paramVal_q [NPAR];
	logic [15:0] activeVal_q [NPAR];
	logic [7:0] histNum_q [HDEPTH];
	logic [HDEPTH-1:0] histValid_q;
	logic [HDEPTH-1:0] histKeep;
	logic firstCycle_q;
	logic powerOnEv;
	logic histClr;
	logic badRegen;
	logic raise;
	logic [7:0] code;
	logic clearReq;
	logic curScreen;
	logic commit;
	logic alarmOn_q;
	logic paramErr_q;
	logic [7:0] curAlarm_q;
	fpa_state_t state_q;
	logic [2:0] screen_q;
	logic [2:0] histIdx;
	logic [2:0] paramIdx_q;
	logic [15:0] editVal_q;
	logic upperView_q;
	logic [BW-1:0] blinkCnt_q;
	logic blinkPhase_q;
	logic [4:0] sym2;
	logic [4:0] sym1;
	logic [4:0] sym0;
	logic [7:0] parNo;
	logic [6:0] seg2_q;
	logic [6:0] seg1_q;
	logic [6:0] seg0_q;
	logic dp_q;
	logic [5:0] word;
	logic access;
	logic apbWr;
	logic [31:0] rdData;
	logic rdErr;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// ==========================================
	// Button synchronisers and press detection
	assign btnRaw = {btnSet, btnDown, btnUp, btnMode};
	for (genvar i = 0; i < 4; i++) begin : g_btn
		// Edge taken from second stage only, first stage may be metastable
		always_ff @(posedge clk or negedge resetn)
		begin
			if (!resetn)
			begin
				sync1_q[i] <= 1'b0;
				sync2_q[i] <= 1'b0;
				prev_q[i] <= 1'b0;
			end
			else
			begin
				sync1_q[i] <= btnRaw[i];
				sync2_q[i] <= sync1_q[i];
				prev_q[i] <= sync2_q[i];
			end
		end
		assign press[i] = sync2_q[i] & ~prev_q[i];
	end

	// ==========================================
	// Power-on event: first cycle after reset, or a power cycle request
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			firstCycle_q <= 1'b1;
		else
			firstCycle_q <= 1'b0;
	end
	assign powerOnEv = firstCycle_q | powerCycle;
	assign histClr = powerOnEv & paramVal_q[IDX_HCLR][0]; // [RL7] [RL8]
	assign badRegen = powerOnEv & ~fpa_regen_ok(paramVal_q[IDX_REGEN]);
	assign raise = alarmEvent | badRegen;
	assign code = alarmEvent ? alarmNumber : ALM_PARAM_FAULT;
	assign curScreen = (state_q == ST_ALARM_VIEW) && (screen_q == 3'h0);
	// Only a clearable alarm whose cause is gone may be cleared
	assign clearReq = alarmCauseGone & alarmClearable & (powerOnEv | (press[B_SET] & curScreen)); // [RL6]
	assign commit = (state_q == ST_PARAM_EDIT) & press[B_SET] & ~raise;

	// ==========================================
	// APB decode
	assign word = paddr[7:2];
	assign access = psel & penable & ~pready_q;
	// Write lands on the edge where the master sees pready
	assign apbWr = psel & penable & pready_q & pwrite & (word < 6'(NPAR));

	// Read mux; unmapped words answer with an error
	always_comb
	begin
		rdData = 32'h0000_0000;
		rdErr = 1'b0;
		histIdx = 3'(word - OFS_HIST0[7:2]);
		if (word < 6'(NPAR))
			rdData = {16'h0000, paramVal_q[word[2:0]]};
		else if (word == OFS_STATUS[7:2])
		begin
			rdData[FLD_ALARM] = alarmOn_q;
			rdData[FLD_PERR] = paramErr_q;
			rdData[FLD_CODE +: 8] = curAlarm_q;
		end
		else if (word >= OFS_HIST0[7:2] && word < OFS_HIST0[7:2] + 6'(HDEPTH))
			rdData = {23'h000000, histValid_q[histIdx], histNum_q[histIdx]};
		else
			rdErr = 1'b1;
	end

	// One wait state: answer registered in the first access cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= access;
			if (access)
			begin
				prdata_q <= pwrite ? 32'h0000_0000 : rdData;
				pslverr_q <= rdErr;
			end
		end
	end

	// ==========================================
	// Stored parameters; bus write wins over a panel commit to the same slot
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int k = 0; k < NPAR; k++)
				paramVal_q[k] <= RST_VAL[k]; // [RL14] [RL15]
		end
		else
		begin
			if (histClr)
				paramVal_q[IDX_HCLR] <= 16'h0000; // [RL8]
			if (commit)
				paramVal_q[paramIdx_q] <= editVal_q;
			if (apbWr)
				paramVal_q[word[2:0]] <= pwdata[15:0];
		end
	end

	// Active copies; starred ones follow the store only at power-on
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int k = 0; k < NPAR; k++)
				activeVal_q[k] <= RST_VAL[k]; // [RL14] [RL15]
		end
		else
		begin
			for (int k = 0; k < NPAR; k++)
				if (powerOnEv || !PWR_CYCLE_MASK[k])
					activeVal_q[k] <= paramVal_q[k]; // [RL12] [RL13]
		end
	end

	// ==========================================
	// Current alarm; a new alarm wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			alarmOn_q <= 1'b0;
			curAlarm_q <= 8'h00;
			paramErr_q <= 1'b0;
		end
		else
		begin
			if (raise)
			begin
				alarmOn_q <= 1'b1;
				curAlarm_q <= code;
			end
			else if (clearReq)
				alarmOn_q <= 1'b0; // [RL6]
			if (badRegen)
				paramErr_q <= 1'b1;
			else if (powerOnEv)
				paramErr_q <= 1'b0;
		end
	end

	// ==========================================
	// History shift register, newest in entry 0
	assign histKeep = histValid_q & ~{HDEPTH{histClr}};
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			histValid_q <= '0;
			for (int k = 0; k < HDEPTH; k++)
				histNum_q[k] <= 8'h00;
		end
		else if (raise)
		begin
			histValid_q <= {histKeep[HDEPTH-2:0], 1'b1}; // [RL3]
			histNum_q[0] <= code;
			// Older entries are wiped too when the erase lands with the alarm
			for (int k = 1; k < HDEPTH; k++)
				histNum_q[k] <= histClr ? 8'h00 : histNum_q[k-1]; // [RL8]
		end
		else
		begin
			histValid_q <= histKeep; // [RL7]
			if (histClr)
				for (int k = 0; k < HDEPTH; k++)
					histNum_q[k] <= 8'h00; // [RL8]
		end
	end

	// ==========================================
	// Screen navigation
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ST_ALARM_VIEW;
			screen_q <= 3'h0;
			paramIdx_q <= 3'h0;
			editVal_q <= 16'h0000;
			upperView_q <= 1'b0;
		end
		else if (raise)
		begin
			state_q <= ST_ALARM_VIEW; // [RL4]
			screen_q <= 3'h0;
		end
		else
		begin
			case (state_q)
				ST_ALARM_VIEW:
					if (press[B_MODE])
						state_q <= ST_PARAM_SEL; // [RL5]
					else if (press[B_UP])
						screen_q <= 3'(screen_q + 3'h1);
					else if (press[B_DOWN])
						screen_q <= 3'(screen_q - 3'h1);
				ST_PARAM_SEL:
					if (press[B_MODE])
						state_q <= ST_ALARM_VIEW;
					else if (press[B_UP])
						paramIdx_q <= 3'(paramIdx_q + 3'h1); // [RL11]
					else if (press[B_DOWN])
						paramIdx_q <= 3'(paramIdx_q - 3'h1); // [RL11]
					else if (press[B_SET])
					begin
						state_q <= ST_PARAM_EDIT;
						editVal_q <= paramVal_q[paramIdx_q];
						upperView_q <= 1'b0;
					end
				ST_PARAM_EDIT:
					if (press[B_MODE])
						upperView_q <= ~upperView_q; // [RL10]
					else if (press[B_UP])
						editVal_q <= 16'(editVal_q + 16'h0001);
					else if (press[B_DOWN])
						editVal_q <= 16'(editVal_q - 16'h0001);
					else if (press[B_SET])
						state_q <= ST_PARAM_SEL;
				default:
					state_q <= ST_ALARM_VIEW;
			endcase
		end
	end

	// ==========================================
	// Half-second divider shared by blinking and alternation
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			blinkCnt_q <= '0;
			blinkPhase_q <= 1'b0;
		end
		else if (blinkCnt_q == BLINK_LAST)
		begin
			blinkCnt_q <= '0;
			blinkPhase_q <= ~blinkPhase_q; // [RL17]
		end
		else
			blinkCnt_q <= BW'(blinkCnt_q + 1'b1);
	end

	// ==========================================
	// Display symbol selection
	// Parameter number held in a net, a function result cannot be sliced
	assign parNo = fpa_param_no(paramIdx_q);
	always_comb
	begin
		sym2 = SYM_BLANK;
		sym1 = SYM_DASH;
		sym0 = SYM_DASH;
		case (state_q)
			ST_ALARM_VIEW:
				if (screen_q == 3'h0)
				begin
					sym2 = SYM_A;
					if (alarmOn_q)
					begin
						sym1 = {1'b0, curAlarm_q[7:4]}; // [RL1]
						sym0 = {1'b0, curAlarm_q[3:0]};
						if (blinkPhase_q)
						begin
							sym2 = SYM_BLANK; // [RL2]
							sym1 = SYM_BLANK;
							sym0 = SYM_BLANK;
						end
					end
				end
				else if (screen_q == 3'h7)
				begin
					sym2 = SYM_E;
					if (paramErr_q && !blinkPhase_q)
					begin
						sym1 = SYM_P; // [RL9]
						sym0 = SYM_A;
					end
					else if (paramErr_q)
					begin
						sym1 = {1'b0, PERR_NO_REGEN[7:4]}; // [RL1]
						sym0 = {1'b0, PERR_NO_REGEN[3:0]};
					end
				end
				else
				begin
					sym2 = {2'b00, screen_q};
					if (histValid_q[3'(screen_q - 3'h1)])
					begin
						sym1 = {1'b0, histNum_q[3'(screen_q - 3'h1)][7:4]}; // [RL3]
						sym0 = {1'b0, histNum_q[3'(screen_q - 3'h1)][3:0]};
					end
				end
			ST_PARAM_SEL:
				if (!blinkPhase_q)
				begin
					sym2 = SYM_P; // [RL9]
					sym1 = SYM_A;
					sym0 = SYM_BLANK;
				end
				else
				begin
					sym1 = {1'b0, parNo[7:4]};
					sym0 = {1'b0, parNo[3:0]};
				end
			ST_PARAM_EDIT:
				if (upperView_q)
				begin
					sym1 = SYM_BLANK; // [RL10]
					sym0 = {1'b0, editVal_q[15:12]};
				end
				else
				begin
					sym2 = {1'b0, editVal_q[11:8]};
					sym1 = {1'b0, editVal_q[7:4]};
					sym0 = {1'b0, editVal_q[3:0]};
				end
			default:
				sym2 = SYM_BLANK;
		endcase
	end

	// Segment registers; dot blinks while an alarm hides behind another screen
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			seg2_q <= 7'h00;
			seg1_q <= 7'h00;
			seg0_q <= 7'h00;
			dp_q <= 1'b0;
		end
		else
		begin
			seg2_q <= fpa_seg(sym2);
			seg1_q <= fpa_seg(sym1);
			seg0_q <= fpa_seg(sym0);
			dp_q <= alarmOn_q & blinkPhase_q & ~curScreen; // [RL5]
		end
	end

	// ==========================================
	// Outputs, all straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign digitSeg2 = seg2_q;
	assign digitSeg1 = seg1_q;
	assign digitSeg0 = seg0_q;
	assign dpThird = dp_q;
	assign alarmActive = alarmOn_q;
	assign contactorEnable = activeVal_q[IDX_CONT][0]; // [RL16]
	assign regenOption = activeVal_q[IDX_REGEN][7:0]; // [RL13]
	assign powerFailTime = activeVal_q[IDX_PFT]; // [RL14]

	// ==========================================
	// Assertions
	alarm_num_a: assert property (@(posedge clk) disable iff (!resetn)
		alarmEvent |=> alarmOn_q && curAlarm_q == $past(alarmNumber)) // [RL1]
		else $error("current alarm number not captured");
	alarm_blink_a: assert property (@(posedge clk) disable iff (!resetn)
		curScreen && alarmOn_q && blinkPhase_q |=> seg0_q == 7'h00 && seg2_q == 7'h00) // [RL2]
		else $error("current alarm screen not blanked in blink phase");
	hist_push_a: assert property (@(posedge clk) disable iff (!resetn)
		raise |=> histNum_q[0] == $past(code) && histValid_q[0]
		&& histNum_q[1] == ($past(histClr) ? 8'h00 : $past(histNum_q[0]))) // [RL3]
		else $error("history did not shift on new alarm");
	alarm_jump_a: assert property (@(posedge clk) disable iff (!resetn)
		raise |=> state_q == ST_ALARM_VIEW && screen_q == 3'h0 ##1 seg2_q == fpa_seg(SYM_A) || $past(blinkPhase_q)) // [RL4]
		else $error("alarm did not force current alarm screen");
	dp_blink_a: assert property (@(posedge clk) disable iff (!resetn)
		!alarmOn_q [*2] |-> !dp_q) // [RL5]
		else $error("third dot lit without alarm");
	set_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		press[B_SET] && curScreen && alarmCauseGone && alarmClearable && !raise |=> !alarmOn_q) // [RL6]
		else $error("SET on current alarm screen did not clear");
	hist_erase_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(histValid_q[HDEPTH-1]) && !$past(raise) |-> $past(histClr)) // [RL7]
		else $error("history lost without history clear");
	hist_auto_a: assert property (@(posedge clk) disable iff (!resetn)
		histClr && !raise && !apbWr |=> histValid_q == '0 && paramVal_q[IDX_HCLR] == 16'h0000) // [RL8]
		else $error("history clear not applied or not self-reset");
	param_alt_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_PARAM_SEL && !blinkPhase_q |=> seg2_q == fpa_seg(SYM_P) && seg1_q == fpa_seg(SYM_A)) // [RL9]
		else $error("parameter group not shown in first phase");
	upper_view_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_PARAM_EDIT && press[B_MODE] && !raise |=> upperView_q != $past(upperView_q)) // [RL10]
		else $error("MODE did not toggle fourth digit view");
	param_step_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == ST_PARAM_SEL && press[B_UP] && !press[B_MODE] && !raise
		|=> paramIdx_q == 3'($past(paramIdx_q) + 3'h1)) // [RL11]
		else $error("UP did not step parameter");
	regen_hold_a: assert property (@(posedge clk) disable iff (!resetn)
		!powerOnEv |=> activeVal_q[IDX_REGEN] == $past(activeVal_q[IDX_REGEN])) // [RL12] [RL13]
		else $error("starred parameter changed without power-on");
	blink_div_a: assert property (@(posedge clk) disable iff (!resetn)
		blinkPhase_q != $past(blinkPhase_q) |-> $past(blinkCnt_q) == BLINK_LAST) // [RL17]
		else $error("blink phase toggled off period");
endmodule // fpa_front_panel

// ---- logic/fpa_pkg.sv ----
// Constants, types and helpers of the front panel alarm and parameter UI.
// Assumes one 10 MHz clock, APB register access and a three digit display.
// Summary of operation
// (RL1) Lower two digits show alarm or parameter number
// (RL2) Current alarm screen blinks while alarm active
// (RL3) Six entry alarm history, newest first
// (RL4) Alarm occurrence forces the current alarm screen
// (RL5) Buttons still work; third decimal point blinks
// (RL6) Clear alarm by power cycle or SET
// (RL7) History erased only by history clear parameter
// (RL8) Enabled history clear erases at power-on, self-resets
// (RL9) Parameter id alternates group and number
// (RL10) MODE toggles fourth digit while editing
// (RL11) UP/DOWN step to adjacent parameter
// (RL12) Starred parameters apply only after power-on
// (RL13) Regenerative option applies after power cycle
// (RL14) Power failure time defaults to 200 ms
// (RL15) Contactor output selection defaults to 0001h
// (RL16) Contactor digit: 0 disabled, 1 enabled
// (RL17) Half-second divider drives blink and alternation
package fpa_pkg;
	// ==========================================
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int BLINK_MS = 500;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_MS / 2;
	// ==========================================
	// Parameter set
	localparam int NPAR = 8;
	localparam int HDEPTH = 6;
	localparam int IDX_REGEN = 0;
	localparam int IDX_CONT = 1;
	localparam int IDX_HCLR = 3;
	localparam int IDX_PFT = 7;
	localparam logic [7:0] PWR_CYCLE_MASK = 8'h5F;
	localparam logic [15:0] RST_REGEN = 16'h0000;
	localparam logic [15:0] RST_CONT = 16'h0001;
	localparam logic [15:0] RST_DISP = 16'h0000;
	localparam logic [15:0] RST_HCLR = 16'h0000;
	localparam logic [15:0] RST_DEB = 16'h0002;
	localparam logic [15:0] RST_FS3 = 16'h0000;
	localparam logic [15:0] RST_FS5 = 16'h0001;
	localparam logic [15:0] RST_PFT = 16'h00C8;
	localparam logic [15:0] RST_VAL [NPAR] = '{RST_REGEN, RST_CONT, RST_DISP, RST_HCLR,
		RST_DEB, RST_FS3, RST_FS5, RST_PFT};
	// ==========================================
	// Register map and fields
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_HIST0 = 8'h24;
	localparam int FLD_ALARM = 0;
	localparam int FLD_PERR = 1;
	localparam int FLD_CODE = 8;
	localparam logic [7:0] ALM_PARAM_FAULT = 8'h37;
	localparam logic [7:0] PERR_NO_REGEN = 8'h01;
	// ==========================================
	// Buttons and display symbols
	localparam int B_MODE = 0;
	localparam int B_UP = 1;
	localparam int B_DOWN = 2;
	localparam int B_SET = 3;
	localparam logic [4:0] SYM_BLANK = 5'h10;
	localparam logic [4:0] SYM_P = 5'h11;
	localparam logic [4:0] SYM_A = 5'h12;
	localparam logic [4:0] SYM_E = 5'h13;
	localparam logic [4:0] SYM_DASH = 5'h14;
	typedef enum logic [2:0] {
		ST_ALARM_VIEW = 3'b001,
		ST_PARAM_SEL = 3'b010,
		ST_PARAM_EDIT = 3'b100
	} fpa_state_t;
	// ==========================================
	// Helpers
	function automatic logic fpa_regen_ok(input logic [15:0] v);
		fpa_regen_ok = (v[15:8] == 8'h00) && (v[7:0] == 8'h00 || v[7:0] == 8'h01 ||
			v[7:0] == 8'h02 || v[7:0] == 8'h13 || v[7:0] == 8'h14);
	endfunction
	function automatic logic [7:0] fpa_param_no(input logic [2:0] i);
		case (i)
			3'h0: fpa_param_no = 8'h01;
			3'h1: fpa_param_no = 8'h02;
			3'h2: fpa_param_no = 8'h08;
			3'h3: fpa_param_no = 8'h09;
			3'h4: fpa_param_no = 8'h12;
			3'h5: fpa_param_no = 8'h15;
			3'h6: fpa_param_no = 8'h17;
			default: fpa_param_no = 8'h18;
		endcase
	endfunction
	// Segment order gfedcba, lit high
	function automatic logic [6:0] fpa_seg(input logic [4:0] s);
		case (s)
			5'h00: fpa_seg = 7'h3F;
			5'h01: fpa_seg = 7'h06;
			5'h02: fpa_seg = 7'h5B;
			5'h03: fpa_seg = 7'h4F;
			5'h04: fpa_seg = 7'h66;
			5'h05: fpa_seg = 7'h6D;
			5'h06: fpa_seg = 7'h7D;
			5'h07: fpa_seg = 7'h07;
			5'h08: fpa_seg = 7'h7F;
			5'h09: fpa_seg = 7'h6F;
			5'h0A: fpa_seg = 7'h77;
			5'h0B: fpa_seg = 7'h7C;
			5'h0C: fpa_seg = 7'h39;
			5'h0D: fpa_seg = 7'h5E;
			5'h0E: fpa_seg = 7'h79;
			5'h0F: fpa_seg = 7'h71;
			5'h11: fpa_seg = 7'h73;
			5'h12: fpa_seg = 7'h77;
			5'h13: fpa_seg = 7'h79;
			5'h14: fpa_seg = 7'h40;
			default: fpa_seg = 7'h00;
		endcase
	endfunction
endpackage
